//--- adcw_defines.svh
`ifndef ADCW_DEFINES_SVH
`define ADCW_DEFINES_SVH

// Special-function register addresses
`define ADCW_ADDR_CONTROL_0 8'he8
`define ADCW_ADDR_RESULT_LOW 8'hbd
`define ADCW_ADDR_RESULT_HIGH 8'hbe
`define ADCW_ADDR_GT_LOW 8'hc3
`define ADCW_ADDR_GT_HIGH 8'hc4
`define ADCW_ADDR_LT_LOW 8'ha5
`define ADCW_ADDR_LT_HIGH 8'ha6
`define ADCW_ADDR_REF_CONTROL 8'hd1

// Converter control 0 field positions
`define ADCW_CC0_ENABLE_BIT 7
`define ADCW_CC0_BURST_BIT 6
`define ADCW_CC0_DONE_BIT 5
`define ADCW_CC0_BUSY_BIT 4
`define ADCW_CC0_WINDOW_BIT 3
`define ADCW_CC0_SRC_MSB 2
`define ADCW_CC0_SRC_LSB 0
`define ADCW_CC0_RESET 8'h00

// Reference control field positions
`define ADCW_REF_LEVEL_BIT 7
`define ADCW_REF_GND_BIT 5
`define ADCW_REF_SRC_MSB 4
`define ADCW_REF_SRC_LSB 3
`define ADCW_REF_TEMP_BIT 2
`define ADCW_REF_RESET 8'h00

// Other reset values
`define ADCW_WORD_RESET 16'h0000
`define ADCW_BYTE_RESET 8'h00
`define ADCW_UNMAPPED_READ 8'h00

// Input multiplexer channel that carries the temperature sensor
`define ADCW_TEMP_CHANNEL 5'h10

`endif

//--- adcw_pkg.sv
package adcw_pkg;

  // Conversion trigger choices
  typedef enum logic [2:0] {
    ADCW_SRC_BUSY_WRITE = 3'b000,
    ADCW_SRC_TIMER0 = 3'b001,
    ADCW_SRC_TIMER2 = 3'b010,
    ADCW_SRC_TIMER3 = 3'b011,
    ADCW_SRC_STROBE = 3'b100
  } adcw_start_source_type;

  // Voltage reference choices
  typedef enum logic [1:0] {
    ADCW_REF_EXT_PIN = 2'b00,
    ADCW_REF_SUPPLY_PIN = 2'b01,
    ADCW_REF_DIGITAL_1V8 = 2'b10,
    ADCW_REF_INTERNAL = 2'b11
  } adcw_ref_source_type;

  // Complete state of the top module
  typedef struct packed {
    logic converter_enable;
    logic burst_enable;
    logic conversion_done_flag;
    logic convert_start_busy;
    logic window_hit_flag;
    logic [2:0] start_source_select;
    logic internal_reference_level;
    logic ground_source_select;
    logic [1:0] reference_source_select;
    logic temp_sensor_enable;
    logic [15:0] result;
    logic [15:0] greater_than_limit;
    logic [15:0] less_than_limit;
    logic [7:0] rdata;
    logic convert_start;
    logic internal_ref_on;
    logic ext_ref_pin_select;
    logic ground_from_analog_ground_pin;
    logic temp_to_positive_input;
  } adcw_state_type;

  // State of the strobe synchroniser
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } adcw_sync_type;

endpackage

//--- adcw_strobe_sync.sv
`timescale 1ns/1ns
// Brings the external convert strobe into the clock domain, flags rising edges
module adcw_strobe_sync
  import adcw_pkg::*;
(
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_pin, // Raw strobe pin
  output logic o_rise // One-cycle pulse on a rising edge
);

  adcw_sync_type st; // Registered state
  adcw_sync_type next_st; // Next state

  // Two flops, then edge detect on the second flop only
  always_comb
  begin
    next_st = st;
    next_st.meta = i_pin;
    next_st.sync = st.meta;
    next_st.last = st.sync;
    next_st.rise = st.sync & ~st.last;
  end

  // State register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_rise = st.rise;

endmodule

//--- adcw_top.sv
`timescale 1ns/1ns
`include "adcw_defines.svh"
// Operation
// - Window compares result against limits automatically
// - Two 16-bit limits, high and low bytes
// - Inside: above greater-than and below less-than
// - Outside: below lower or above upper bound
// - Limit ordering alone picks inside or outside
// - Window flag drives interrupt, stays readable
// - Compare uses result as justified
// - Select 00 uses external reference pin
// - Select 11 uses internal reference
// - Internal reference powered only when converter needs
// - Level bit picks 1.65 V or 2.4 V
// - 01 supply pin, 10 1.8 V supply
// - Internal sources never driven onto pin
// - Ground select picks analogue ground pin
// - Temperature sampling always uses chip ground
// - 1.65 V reference converts on chip ground
// - Temperature sensor enable bit switches sensor
// - Sensor channel feeds positive converter input
// - Control register bit layout, reset zero
// - Window flag sticky until software clears
// - Start source selects conversion trigger
module adcw_top
  import adcw_pkg::*;
(
  input wire logic i_ref_clk, // System clock, 100 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic [7:0] i_sfr_addr, // Register address
  input wire logic i_sfr_wr, // Register write strobe
  input wire logic i_sfr_rd, // Register read strobe
  input wire logic [7:0] i_sfr_wdata, // Register write data
  output logic [7:0] o_sfr_rdata, // Register read data, one cycle later
  input wire logic i_timer0_ovf, // Timer 0 overflow pulse
  input wire logic i_timer2_ovf, // Timer 2 overflow pulse
  input wire logic i_timer3_ovf, // Timer 3 overflow pulse
  input wire logic i_convert_strobe, // External convert strobe pin
  input wire logic i_result_valid, // Result update pulse from converter
  input wire logic [15:0] i_result_data, // Formatted result word
  input wire logic i_converter_active, // Converter needs its reference
  input wire logic i_tracking, // Converter in tracking phase
  input wire logic i_converting, // Converter in conversion phase
  input wire logic [4:0] i_mux_channel, // Selected positive channel
  output logic o_convert_start, // One-cycle start pulse to converter
  output logic o_converter_enable, // Converter power enable
  output logic o_burst_enable, // Burst mode enable
  output logic o_conversion_done_flag, // Done flag, interrupt request
  output logic o_window_hit_flag, // Window flag, interrupt request
  output logic [1:0] o_reference_source_select, // Reference mux control
  output logic o_internal_ref_on, // Internal reference power
  output logic o_internal_reference_level, // 0 1.65 V, 1 2.4 V
  output logic o_ext_ref_pin_select, // Reference pin connected as input
  output logic o_ground_from_analog_ground_pin, // 1 analogue ground pin, 0 chip ground
  output logic o_temp_sensor_enable, // Temperature sensor power
  output logic o_temp_to_positive_input // Sensor routed to positive input
);

  adcw_state_type st; // Registered state
  adcw_state_type next_st; // Next state
  logic strobe_rise; // Synchronised strobe edge

  // Window test: limit order picks inside or outside detection
  function automatic logic window_hit(input logic [15:0] value,
                                      input logic [15:0] gt_lim,
                                      input logic [15:0] lt_lim);
    logic hit;
    hit = 1'b0;
    if (lt_lim > gt_lim)
    begin
      hit = (value > gt_lim) && (value < lt_lim);
    end
    else
    begin
      hit = (value < lt_lim) || (value > gt_lim);
    end
    return hit;
  endfunction

  // Byte write into one half of a 16-bit register
  function automatic logic [15:0] put_byte(input logic [15:0] word,
                                           input logic high,
                                           input logic [7:0] data);
    logic [15:0] res;
    res = word;
    if (high)
    begin
      res[15:8] = data;
    end
    else
    begin
      res[7:0] = data;
    end
    return res;
  endfunction

  // Strobe pin synchroniser and edge detector
  adcw_strobe_sync u_strobe_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pin(i_convert_strobe),
    .o_rise(strobe_rise)
  );

  // Next-state logic for registers, triggers, flags and analogue controls
  always_comb
  begin
    logic wr_cc0; // Write to control register
    logic busy_write; // Software start request
    logic trig; // Selected trigger fired
    logic hit; // Window condition on new result
    logic [7:0] rd; // Read mux
    wr_cc0 = 1'b0;
    busy_write = 1'b0;
    trig = 1'b0;
    hit = 1'b0;
    rd = `ADCW_UNMAPPED_READ;
    next_st = st;
    next_st.convert_start = 1'b0;
    wr_cc0 = i_sfr_wr && (i_sfr_addr == `ADCW_ADDR_CONTROL_0);
    busy_write = wr_cc0 && i_sfr_wdata[`ADCW_CC0_BUSY_BIT];

    // Control register writes, done and window flags written here too; busy handled below
    if (wr_cc0)
    begin
      next_st.converter_enable = i_sfr_wdata[`ADCW_CC0_ENABLE_BIT];
      next_st.burst_enable = i_sfr_wdata[`ADCW_CC0_BURST_BIT];
      next_st.start_source_select = i_sfr_wdata[`ADCW_CC0_SRC_MSB:`ADCW_CC0_SRC_LSB];
      next_st.conversion_done_flag = i_sfr_wdata[`ADCW_CC0_DONE_BIT];
      next_st.window_hit_flag = i_sfr_wdata[`ADCW_CC0_WINDOW_BIT];
    end

    // Limit register writes byte by byte, reference control register writes
    if (i_sfr_wr)
    begin
      case (i_sfr_addr)
        `ADCW_ADDR_GT_LOW:
        begin
          next_st.greater_than_limit = put_byte(st.greater_than_limit, 1'b0,
                                                i_sfr_wdata);
        end
        `ADCW_ADDR_GT_HIGH:
        begin
          next_st.greater_than_limit = put_byte(st.greater_than_limit, 1'b1,
                                                i_sfr_wdata);
        end
        `ADCW_ADDR_LT_LOW:
        begin
          next_st.less_than_limit = put_byte(st.less_than_limit, 1'b0,
                                             i_sfr_wdata);
        end
        `ADCW_ADDR_LT_HIGH:
        begin
          next_st.less_than_limit = put_byte(st.less_than_limit, 1'b1,
                                             i_sfr_wdata);
        end
        `ADCW_ADDR_REF_CONTROL:
        begin
          next_st.internal_reference_level = i_sfr_wdata[`ADCW_REF_LEVEL_BIT];
          next_st.ground_source_select = i_sfr_wdata[`ADCW_REF_GND_BIT];
          next_st.reference_source_select =
            i_sfr_wdata[`ADCW_REF_SRC_MSB:`ADCW_REF_SRC_LSB];
          next_st.temp_sensor_enable = i_sfr_wdata[`ADCW_REF_TEMP_BIT];
        end
        default:
        begin
          // Other addresses hold nothing writable here
        end
      endcase
    end

    // Trigger selection; reserved codes start nothing
    case (st.start_source_select)
      ADCW_SRC_BUSY_WRITE:
      begin
        trig = busy_write;
      end
      ADCW_SRC_TIMER0:
      begin
        trig = i_timer0_ovf;
      end
      ADCW_SRC_TIMER2:
      begin
        trig = i_timer2_ovf;
      end
      ADCW_SRC_TIMER3:
      begin
        trig = i_timer3_ovf;
      end
      ADCW_SRC_STROBE:
      begin
        trig = strobe_rise;
      end
      default:
      begin
        trig = 1'b0;
      end
    endcase

    // Busy reads as written unless hardware owns it
    next_st.convert_start_busy = wr_cc0 ? busy_write : st.convert_start_busy;
    if (trig && (st.converter_enable || st.burst_enable))
    begin
      next_st.convert_start = 1'b1;
      next_st.convert_start_busy = 1'b1;
    end
    else if (busy_write)
    begin
      next_st.convert_start_busy = 1'b0; // Ignored start does not stick
    end

    // Result update: store word, set done, judge window in the same cycle
    if (i_result_valid)
    begin
      next_st.result = i_result_data;
      next_st.convert_start_busy = 1'b0;
      next_st.conversion_done_flag = 1'b1; // Set wins over a clearing write
      hit = window_hit(i_result_data, st.greater_than_limit,
                       st.less_than_limit);
      if (hit)
      begin
        next_st.window_hit_flag = 1'b1; // Set wins over a clearing write
      end
    end

    // Read multiplexer, data registered
    case (i_sfr_addr)
      `ADCW_ADDR_CONTROL_0:
      begin
        rd = {st.converter_enable, st.burst_enable, st.conversion_done_flag,
              st.convert_start_busy, st.window_hit_flag,
              st.start_source_select};
      end
      `ADCW_ADDR_RESULT_LOW:
      begin
        rd = st.result[7:0];
      end
      `ADCW_ADDR_RESULT_HIGH:
      begin
        rd = st.result[15:8];
      end
      `ADCW_ADDR_GT_LOW:
      begin
        rd = st.greater_than_limit[7:0];
      end
      `ADCW_ADDR_GT_HIGH:
      begin
        rd = st.greater_than_limit[15:8];
      end
      `ADCW_ADDR_LT_LOW:
      begin
        rd = st.less_than_limit[7:0];
      end
      `ADCW_ADDR_LT_HIGH:
      begin
        rd = st.less_than_limit[15:8];
      end
      `ADCW_ADDR_REF_CONTROL:
      begin
        rd = `ADCW_BYTE_RESET;
        rd[`ADCW_REF_LEVEL_BIT] = st.internal_reference_level;
        rd[`ADCW_REF_GND_BIT] = st.ground_source_select;
        rd[`ADCW_REF_SRC_MSB:`ADCW_REF_SRC_LSB] = st.reference_source_select;
        rd[`ADCW_REF_TEMP_BIT] = st.temp_sensor_enable;
      end
      default:
      begin
        rd = `ADCW_UNMAPPED_READ;
      end
    endcase
    if (i_sfr_rd)
    begin
      next_st.rdata = rd;
    end

    // Internal reference powered on demand only when selected
    next_st.internal_ref_on = (st.reference_source_select == ADCW_REF_INTERNAL)
                              && i_converter_active;
    // Pin joins the mux only for the external choice, never driven
    next_st.ext_ref_pin_select =
      (st.reference_source_select == ADCW_REF_EXT_PIN);

    // Ground source with chip-ground overrides
    next_st.ground_from_analog_ground_pin = st.ground_source_select;
    if (i_tracking && (i_mux_channel == `ADCW_TEMP_CHANNEL))
    begin
      next_st.ground_from_analog_ground_pin = 1'b0;
    end
    if (i_converting && (st.reference_source_select == ADCW_REF_INTERNAL)
        && !st.internal_reference_level)
    begin
      next_st.ground_from_analog_ground_pin = 1'b0;
    end

    // Sensor presented on the positive input when its channel is picked
    next_st.temp_to_positive_input = st.temp_sensor_enable
                                     && (i_mux_channel == `ADCW_TEMP_CHANNEL);
  end

  // State register, everything cleared on reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign o_sfr_rdata = st.rdata;
  assign o_convert_start = st.convert_start;
  assign o_converter_enable = st.converter_enable;
  assign o_burst_enable = st.burst_enable;
  assign o_conversion_done_flag = st.conversion_done_flag;
  assign o_window_hit_flag = st.window_hit_flag;
  assign o_reference_source_select = st.reference_source_select;
  assign o_internal_ref_on = st.internal_ref_on;
  assign o_internal_reference_level = st.internal_reference_level;
  assign o_ext_ref_pin_select = st.ext_ref_pin_select;
  assign o_ground_from_analog_ground_pin = st.ground_from_analog_ground_pin;
  assign o_temp_sensor_enable = st.temp_sensor_enable;
  assign o_temp_to_positive_input = st.temp_to_positive_input;

endmodule

//--- adcw_top_assertions.sv
`timescale 1ns/1ns
// Port-level checks on the converter control block
module adcw_checker
(
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst, // Reset
  input wire logic [7:0] i_sfr_addr, // Register address
  input wire logic i_sfr_wr, // Write strobe
  input wire logic i_result_valid, // Result update
  input wire logic i_converter_active, // Reference needed
  input wire logic i_tracking, // Tracking phase
  input wire logic i_converting, // Conversion phase
  input wire logic [4:0] i_mux_channel, // Positive channel
  input wire logic o_convert_start, // Start pulse
  input wire logic o_converter_enable, // Enable bit
  input wire logic o_burst_enable, // Burst bit
  input wire logic o_conversion_done_flag, // Done flag
  input wire logic o_window_hit_flag, // Window flag
  input wire logic [1:0] o_reference_source_select, // Reference select
  input wire logic o_internal_ref_on, // Internal reference power
  input wire logic o_internal_reference_level, // Level bit
  input wire logic o_ext_ref_pin_select, // Pin reference used
  input wire logic o_ground_from_analog_ground_pin, // Ground pin choice
  input wire logic o_temp_to_positive_input // Sensor routing
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Start pulse only when enable or burst was set the cycle before
  property p_start; o_convert_start |-> $past(o_converter_enable || o_burst_enable); endproperty
  a_start: assert property (p_start) else $error("start while disabled");
  // Pin choice lags the select by one cycle, so the edge just out of reset is skipped
  property p_ext; (!$past(i_rst) && o_reference_source_select == 2'b00
    && $past(o_reference_source_select) == 2'b00) |-> o_ext_ref_pin_select; endproperty
  a_ext: assert property (p_ext) else $error("pin reference not used");
  property p_int; (o_reference_source_select != 2'b00 && $past(o_reference_source_select) != 2'b00)
    |-> !o_ext_ref_pin_select; endproperty
  a_int: assert property (p_int) else $error("internal source on pin");
  property p_iref; ($past(i_converter_active) && $past(o_reference_source_select) == 2'b11
    && o_reference_source_select == 2'b11) |-> o_internal_ref_on; endproperty
  a_iref: assert property (p_iref) else $error("internal reference off");
  property p_g16; ($past(i_converting) && $past(o_reference_source_select) == 2'b11
    && !$past(o_internal_reference_level) && !o_internal_reference_level
    && o_reference_source_select == 2'b11) |-> !o_ground_from_analog_ground_pin; endproperty
  a_g16: assert property (p_g16) else $error("low reference not on chip ground");
  property p_g15; $past(i_tracking && i_mux_channel == 5'h10) |-> !o_ground_from_analog_ground_pin; endproperty
  a_g15: assert property (p_g15) else $error("sensor sample not on chip ground");
  property p_temp; o_temp_to_positive_input |-> $past(i_mux_channel) == 5'h10; endproperty
  a_temp: assert property (p_temp) else $error("sensor routed off channel");
  property p_sticky; ($past(o_window_hit_flag) && !$past(i_sfr_wr && i_sfr_addr == 8'he8))
    |-> o_window_hit_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("window flag dropped");
  property p_rise; $rose(o_window_hit_flag)
    |-> $past(i_result_valid || (i_sfr_wr && i_sfr_addr == 8'he8)); endproperty
  a_rise: assert property (p_rise) else $error("window flag without update");
  property p_done; $past(i_result_valid) |-> o_conversion_done_flag; endproperty
  a_done: assert property (p_done) else $error("done flag missing");
  // Main scenarios reached
  c_start: cover property (o_convert_start);
  c_win: cover property ($rose(o_window_hit_flag));
  c_iref: cover property (o_internal_ref_on);
endmodule
bind adcw_top adcw_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_result_valid(i_result_valid), .i_converter_active(i_converter_active),
  .i_tracking(i_tracking), .i_converting(i_converting), .i_mux_channel(i_mux_channel),
  .o_convert_start(o_convert_start), .o_converter_enable(o_converter_enable),
  .o_burst_enable(o_burst_enable), .o_conversion_done_flag(o_conversion_done_flag),
  .o_window_hit_flag(o_window_hit_flag), .o_reference_source_select(o_reference_source_select),
  .o_internal_ref_on(o_internal_ref_on), .o_internal_reference_level(o_internal_reference_level),
  .o_ext_ref_pin_select(o_ext_ref_pin_select), .o_ground_from_analog_ground_pin(o_ground_from_analog_ground_pin),
  .o_temp_to_positive_input(o_temp_to_positive_input));

//--- adcw_top_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the converter control block
module adcw_top_bench;
  import adcw_pkg::*;
  logic clk, rst, wr, rd, t0, t2, t3, stb, rv, act, trk, cnv; // Bench-driven inputs
  logic [7:0] addr, wd, rdata; // Register bus
  logic [15:0] rdat; // Result word
  logic [4:0] ch; // Mux channel
  logic cs, en, bu, dn, wh, iro, lvl, ext, agd, ten, tpi; // Observed outputs
  logic [1:0] rs; // Observed reference select
  int failures = 0; // Mismatch count
  int num_checks = 0; // Comparison count
  int cyc = 0; // Cycle count for timeout
  adcw_top dut (.i_ref_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_timer0_ovf(t0), .i_timer2_ovf(t2),
    .i_timer3_ovf(t3), .i_convert_strobe(stb), .i_result_valid(rv), .i_result_data(rdat),
    .i_converter_active(act), .i_tracking(trk), .i_converting(cnv), .i_mux_channel(ch),
    .o_convert_start(cs), .o_converter_enable(en), .o_burst_enable(bu),
    .o_conversion_done_flag(dn), .o_window_hit_flag(wh), .o_reference_source_select(rs),
    .o_internal_ref_on(iro), .o_internal_reference_level(lvl), .o_ext_ref_pin_select(ext),
    .o_ground_from_analog_ground_pin(agd), .o_temp_sensor_enable(ten), .o_temp_to_positive_input(tpi));
  // Clock at 100 MHz
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Word compare
  task chk(input logic [15:0] e, input logic [15:0] s, input string n);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bit compare
  task chkb(input logic e, input logic s, input string n);
    chk({15'h0, e}, {15'h0, s}, n);
  endtask
  // Register write, held one edge
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  // Register read and compare
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk({8'h00, e}, {8'h00, rdata}, "rdata");
  endtask
  // Result update, optional flag clear first
  task win(input logic [15:0] r, input logic e, input logic clr);
    if (clr)
      wrr(8'he8, 8'h80);
    @(posedge clk);
    rv <= 1;
    rdat <= r;
    @(posedge clk);
    rv <= 0;
    @(negedge clk);
    chkb(e, wh, "window");
    chkb(1'b1, dn, "done");
  endtask
  // Reset values, layout, unmapped address
  task t_regs;
    rdc(8'he8, 8'h00);
    rdc(8'hd1, 8'h00);
    rdc(8'h00, 8'h00);
    wrr(8'he8, 8'he8);
    rdc(8'he8, 8'he8);
    chkb(1'b1, en, "enable");
    chkb(1'b1, bu, "burst");
    wrr(8'he8, 8'h00);
    rdc(8'he8, 8'h00);
    $display("done regs");
  endtask
  // Inside then outside window, stickiness, read-only result
  task t_window;
    logic [15:0] v [5];
    logic [4:0] m;
    v = '{16'h0040, 16'h0041, 16'h007f, 16'h0080, 16'h0000};
    m = 5'b00110;
    wrr(8'hc3, 8'h40);
    wrr(8'hc4, 8'h00);
    wrr(8'ha5, 8'h80);
    wrr(8'ha6, 8'h00);
    for (int i = 0; i < 5; i++)
      win(v[i], m[i], 1'b1);
    win(16'h0041, 1'b1, 1'b1);
    win(16'h0000, 1'b1, 1'b0);
    win(16'h1234, 1'b0, 1'b1);
    wrr(8'hbd, 8'hff);
    rdc(8'hbd, 8'h34);
    rdc(8'hbe, 8'h12);
    wrr(8'hc3, 8'h80);
    wrr(8'ha5, 8'h40);
    v = '{16'h003f, 16'h0040, 16'h0080, 16'h0081, 16'h0000};
    m = 5'b11001;
    for (int i = 0; i < 5; i++)
      win(v[i], m[i], 1'b1);
    $display("done window");
  endtask
  // Write control, fire triggers {strobe,t3,t2,t0}, count starts
  task sc(input logic [7:0] c, input logic [3:0] f, input int n);
    logic [15:0] k;
    wrr(8'he8, c);
    k = 16'h0000;
    @(negedge clk);
    k += cs;
    @(posedge clk);
    {stb, t3, t2, t0} <= f;
    @(posedge clk);
    {t3, t2, t0} <= 3'b000;
    repeat (6)
    begin
      @(negedge clk);
      k += cs;
    end
    @(posedge clk);
    stb <= 0;
    chk(16'(n), k, "starts");
  endtask
  // Every trigger source, reserved code, disabled converter
  task t_start;
    sc(8'h81, 4'h1, 1);
    sc(8'h81, 4'h6, 0);
    sc(8'h82, 4'h2, 1);
    sc(8'h83, 4'h4, 1);
    sc(8'h84, 4'h8, 1);
    sc(8'h80, 4'h0, 0);
    sc(8'h90, 4'h0, 1);
    rdc(8'he8, 8'h90);
    sc(8'h85, 4'hf, 0);
    sc(8'h01, 4'h1, 0);
    sc(8'h41, 4'h1, 1);
    $display("done start");
  endtask
  // Reference selection over every code and level
  task t_ref;
    logic [2:0] j;
    act <= 1;
    for (int i = 0; i < 8; i++)
    begin
      j = i[2:0];
      wrr(8'hd1, {j[2], 2'b00, j[1:0], 3'b000});
      repeat (2) @(negedge clk);
      chk({14'h0, j[1:0]}, {14'h0, rs}, "refsel");
      chkb(j[1:0] == 2'b00, ext, "pinref");
      chkb(j[1:0] == 2'b11, iro, "iref");
      chkb(j[2], lvl, "level");
      rdc(8'hd1, {j[2], 2'b00, j[1:0], 3'b000});
    end
    @(posedge clk);
    act <= 0;
    repeat (2) @(negedge clk);
    chkb(1'b0, iro, "iref");
    $display("done ref");
  endtask
  // Ground choice with its overrides
  task g(input logic [7:0] d, input logic tk, input logic cv, input logic [4:0] c, input logic e);
    wrr(8'hd1, d);
    trk <= tk;
    cnv <= cv;
    ch <= c;
    repeat (2) @(negedge clk);
    chkb(e, agd, "ground");
  endtask
  // Ground overrides and temperature sensor
  task t_gnd;
    g(8'h38, 0, 1, 5'h00, 0);
    g(8'h38, 0, 0, 5'h00, 1);
    g(8'hb8, 0, 1, 5'h00, 1);
    g(8'h20, 1, 0, 5'h10, 0);
    g(8'h20, 1, 0, 5'h01, 1);
    g(8'h04, 0, 0, 5'h10, 0);
    chkb(1'b1, ten, "tempen");
    chkb(1'b1, tpi, "temppos");
    g(8'h00, 0, 0, 5'h10, 0);
    chkb(1'b0, ten, "tempen");
    chkb(1'b0, tpi, "temppos");
    $display("done ground");
  endtask
  // Verdict and end of run
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      stop_test;
    end
  end
  // Main sequence
  initial
  begin
    {rst, wr, rd, t0, t2, t3, stb, rv, act, trk, cnv} = 11'h400;
    addr = 8'h00;
    wd = 8'h00;
    rdat = 16'h0000;
    ch = 5'h00;
    repeat (12) @(posedge clk);
    rst <= 0;
    t_regs;
    t_window;
    t_start;
    t_ref;
    t_gnd;
    stop_test;
  end
endmodule
